//--- hw/ead_map.svh
`ifndef EAD_MAP_SVH
`define EAD_MAP_SVH

// register byte offsets on the axi4-lite slave
`define EAD_ADDR_W 8
`define EAD_REG_CTRL 8'h00
`define EAD_REG_FRAMES 8'h04
`define EAD_REG_RSVD 8'h08
`define EAD_REG_LAST 8'h0c

// control register fields and reset value
`define EAD_CTRL_ENA_BIT 0
`define EAD_CTRL_CLR_BIT 1
`define EAD_CTRL_RST 1'b1

// last-flags register fields
`define EAD_LAST_PROT_RSVD_BIT 0
`define EAD_LAST_STRIP_RSVD_BIT 1
`define EAD_LAST_KEY_RSVD_BIT 2
`define EAD_LAST_STRIP_CLIP_BIT 3
`define EAD_LAST_W 4

// field widths
`define EAD_MEP_W 12
`define EAD_HW_W 5

// protection selector encodings
`define EAD_PROT_NONE 2'h0
`define EAD_PROT_ON_ACTIVE 2'h1
`define EAD_PROT_ON_IDLE 2'h2

// label strip count encodings
`define EAD_STRIP_HDR 5'h00
`define EAD_STRIP_NONE 5'h01
`define EAD_STRIP_MAX 5'h15

// forward selector and pipeline action encodings
`define EAD_FWD_NONE 2'h0
`define EAD_FWD_COPY 2'h1
`define EAD_FWD_REDIR 2'h2
`define EAD_FWD_DISCARD 2'h3
`define EAD_PACT_HOST 1'b0
`define EAD_PACT_LBK 1'b1

// mapping key encodings
`define EAD_KEY_QOS 4'h0
`define EAD_KEY_DP_QOS 4'h1
`define EAD_KEY_DSCP 4'h2
`define EAD_KEY_DP_DSCP 4'h3
`define EAD_KEY_DP_TOS 4'h4
`define EAD_KEY_PCP 4'h5
`define EAD_KEY_DP_PCP 4'h6
`define EAD_KEY_DEI_PCP 4'h7
`define EAD_KEY_TC 4'h8
`define EAD_KEY_DP_TC 4'h9
`define EAD_KEY_POP_PCP 4'ha
`define EAD_KEY_DP_POP_PCP 4'hb
`define EAD_KEY_POP_DEI_PCP 4'hc
`define EAD_KEY_COS_ID 4'hd
`define EAD_KEY_DP_COS_ID 4'he

`endif

//--- hw/ead_pkg.sv
`include "ead_map.svh"

package ead_pkg;

    // action word of the egress stage-zero lookup
    typedef struct packed {
        logic [1:0] protection_sel;
        logic [9:0] tunnel_label_index;
        logic [9:0] tunnel_label_index_alt;
        logic [`EAD_MEP_W-1:0] maintenance_endpoint_index;
        logic [`EAD_MEP_W-1:0] maintenance_endpoint_index_alt;
        logic [4:0] label_strip_count;
        logic [12:0] service_counter_base;
        logic [12:0] service_counter_base_alt;
        logic [23:0] service_class_offsets;
        logic [3:0][8:0] map_table_index;
        logic [3:0][3:0] map_key;
        logic [1:0] forward_selector;
        logic [2:0] host_extract_queue;
        logic pipeline_action;
    } ead_action_type;

    // internal frame header attributes
    typedef struct packed {
        logic prot_active;
        logic [`EAD_HW_W-1:0] header_strip_halfwords;
        logic [2:0] class_of_service_id;
        logic [2:0] qos_class;
        logic [1:0] drop_prec;
        logic [5:0] dscp;
        logic [2:0] tos_precedence;
        logic [2:0] pcp;
        logic dei;
        logic [2:0] traffic_class;
        logic [2:0] popped_pcp;
        logic popped_dei;
    } ead_hdr_type;

    // decoded result towards rewriter, counters and queue system
    typedef struct packed {
        logic tunnel_push_ena;
        logic [9:0] tunnel_label_index;
        logic [`EAD_MEP_W-1:0] maintenance_endpoint_index;
        logic [5:0] strip_bytes;
        logic [12:0] service_counter_index;
        logic [1:0][11:0] map_a_addr;
        logic [1:0][11:0] map_b_addr;
        logic copy_loopback;
        logic redirect_loopback;
        logic discard;
        logic host_extraction;
        logic [2:0] host_extract_queue;
        logic loopback_assembly;
    } ead_result_type;

endpackage : ead_pkg

//--- hw/ead_map_addr.sv
`timescale 1ns/1ns
`include "ead_map.svh"

// forms one mapping table address from the table's base index and key
module ead_map_addr (
    input wire logic [8:0] map_index,
    input wire logic [3:0] map_key,
    input wire ead_pkg::ead_hdr_type hdr,
    output logic [11:0] map_addr,
    output logic key_reserved
);
    import ead_pkg::*;

    // offset added to the base; widest key spans 256 entries
    function automatic logic [7:0] key_offset(input logic [3:0] key, input ead_hdr_type h);
        logic [7:0] off;
        off = 8'h00;
        case (key)
            `EAD_KEY_QOS: off = {5'h00, h.qos_class};
            `EAD_KEY_DP_QOS: off = {3'h0, h.drop_prec, h.qos_class};
            `EAD_KEY_DSCP: off = {2'h0, h.dscp};
            `EAD_KEY_DP_DSCP: off = {h.drop_prec, h.dscp};
            `EAD_KEY_DP_TOS: off = {3'h0, h.drop_prec, h.tos_precedence};
            `EAD_KEY_PCP: off = {5'h00, h.pcp};
            `EAD_KEY_DP_PCP: off = {3'h0, h.drop_prec, h.pcp};
            `EAD_KEY_DEI_PCP: off = {4'h0, h.dei, h.pcp};
            `EAD_KEY_TC: off = {5'h00, h.traffic_class};
            `EAD_KEY_DP_TC: off = {3'h0, h.drop_prec, h.traffic_class};
            `EAD_KEY_POP_PCP: off = {5'h00, h.popped_pcp};
            `EAD_KEY_DP_POP_PCP: off = {3'h0, h.drop_prec, h.popped_pcp};
            `EAD_KEY_POP_DEI_PCP: off = {4'h0, h.popped_dei, h.popped_pcp};
            `EAD_KEY_COS_ID: off = {5'h00, h.class_of_service_id};
            `EAD_KEY_DP_COS_ID: off = {3'h0, h.drop_prec, h.class_of_service_id};
            default: off = 8'h00; // undefined key: base entry only
        endcase
        return off;
    endfunction : key_offset

    // base supplies bits 11:3; the key offset is added, so wide keys carry upward
    always_comb begin
        map_addr = {map_index, 3'h0} + {4'h0, key_offset(map_key, hdr)};
        key_reserved = (map_key > `EAD_KEY_DP_COS_ID);
    end

endmodule : ead_map_addr

//--- hw/ead_top.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.

`timescale 1ns/1ns
`include "ead_map.svh"

module ead_top (
    input wire logic core_clk,
    input wire logic rstn,
    // lookup result and frame header, one frame per cycle
    input wire logic act_valid,
    input wire ead_pkg::ead_action_type action,
    input wire ead_pkg::ead_hdr_type hdr,
    output logic res_valid,
    output ead_pkg::ead_result_type result,

    // axi4-lite slave
    input wire logic [`EAD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`EAD_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import ead_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register-file state
    logic ctrl_ena_ff;
    logic [31:0] frames_ff;
    logic [31:0] rsvd_ff;
    logic [`EAD_LAST_W-1:0] last_flags_ff;

    // axi state
    logic awready_ff;
    logic wready_ff;
    logic [`EAD_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // decode pipeline state
    logic res_valid_ff;
    ead_result_type result_ff;

    // combinational decode results
    ead_result_type nxt_result;
    logic use_alt;
    logic prot_rsvd;

    // strip and counter datapath
    logic strip_rsvd;
    logic strip_clip;
    logic [5:0] hdr_bytes;
    logic [5:0] req_bytes;
    logic [12:0] counter_base;
    logic [4:0] offset_lsb;
    logic [2:0] class_offset;

    // mapping and bus decode
    logic [11:0] map_addr [4];
    logic [3:0] key_rsvd;
    logic nxt_any_rsvd;
    logic [`EAD_LAST_W-1:0] nxt_last_flags;
    logic take_frame;
    logic aw_held;
    logic w_held;
    logic do_write;
    logic clr_pulse;
    logic ctrl_wr;

    // one address former per mapping table, each with its own key
    for (genvar t = 0; t < 4; t++) begin : g_map
        ead_map_addr u_map_addr (
            .map_index(action.map_table_index[t]),
            .map_key(action.map_key[t]),
            .hdr(hdr),
            .map_addr(map_addr[t]),
            .key_reserved(key_rsvd[t])
        );
    end

    // protection: choose alternate indices from the header's protect-active flag
    always_comb begin
        case (action.protection_sel)
            `EAD_PROT_NONE: use_alt = 1'b0;
            `EAD_PROT_ON_ACTIVE: use_alt = hdr.prot_active;
            `EAD_PROT_ON_IDLE: use_alt = ~hdr.prot_active;
            default: use_alt = 1'b0; // reserved selector ignored
        endcase

        prot_rsvd = (action.protection_sel == 2'h3);
    end

    // label strip byte count; reserved counts fall back to the header amount
    always_comb begin
        hdr_bytes = {hdr.header_strip_halfwords, 1'b0};
        strip_rsvd = 1'b0;

        if (action.label_strip_count == `EAD_STRIP_HDR) begin
            req_bytes = hdr_bytes;
        end else if (action.label_strip_count == `EAD_STRIP_NONE) begin
            req_bytes = 6'h00;
        end else if (action.label_strip_count <= `EAD_STRIP_MAX) begin
            req_bytes = {action.label_strip_count, 1'b0};
        end else begin
            req_bytes = hdr_bytes;
            strip_rsvd = 1'b1;
        end

        strip_clip = (req_bytes > hdr_bytes);
    end

    // service counter index: selected base plus the per-class 3-bit offset
    always_comb begin
        counter_base = use_alt ? action.service_counter_base_alt : action.service_counter_base;
        // 3 x class id as a shift plus an add
        offset_lsb = {hdr.class_of_service_id, 1'b0} + {2'h0, hdr.class_of_service_id};
        class_offset = action.service_class_offsets[offset_lsb +: 3];
    end

    // assemble the full result word
    always_comb begin
        nxt_result = '0;

        nxt_result.tunnel_label_index = use_alt ? action.tunnel_label_index_alt
                                                : action.tunnel_label_index;
        nxt_result.tunnel_push_ena = (nxt_result.tunnel_label_index != 10'h000);
        nxt_result.maintenance_endpoint_index = use_alt ? action.maintenance_endpoint_index_alt
                                                        : action.maintenance_endpoint_index;

        nxt_result.strip_bytes = strip_clip ? hdr_bytes : req_bytes;
        nxt_result.service_counter_index = counter_base + {10'h000, class_offset};

        nxt_result.map_a_addr[0] = map_addr[0];
        nxt_result.map_a_addr[1] = map_addr[1];
        nxt_result.map_b_addr[0] = map_addr[2];
        nxt_result.map_b_addr[1] = map_addr[3];

        nxt_result.copy_loopback = (action.forward_selector == `EAD_FWD_COPY);
        nxt_result.redirect_loopback = (action.forward_selector == `EAD_FWD_REDIR);
        nxt_result.discard = (action.forward_selector == `EAD_FWD_DISCARD);

        nxt_result.host_extraction = (action.forward_selector != `EAD_FWD_NONE)
                                     && (action.pipeline_action == `EAD_PACT_HOST);
        nxt_result.loopback_assembly = (action.forward_selector != `EAD_FWD_NONE)
                                       && (action.pipeline_action == `EAD_PACT_LBK);

        // queue is zero unless it is meaningful, so stale entries never leak out
        nxt_result.host_extract_queue = nxt_result.host_extraction ? action.host_extract_queue
                                                                   : 3'h0;
    end

    // flags describing the frame just decoded
    always_comb begin
        nxt_last_flags = '0;
        nxt_last_flags[`EAD_LAST_PROT_RSVD_BIT] = prot_rsvd;
        nxt_last_flags[`EAD_LAST_STRIP_RSVD_BIT] = strip_rsvd;
        nxt_last_flags[`EAD_LAST_KEY_RSVD_BIT] = |key_rsvd;
        nxt_last_flags[`EAD_LAST_STRIP_CLIP_BIT] = strip_clip;

        // several reserved codes count once
        nxt_any_rsvd = prot_rsvd | strip_rsvd | (|key_rsvd);
    end

    // a disabled decoder drops frames: nothing is presented downstream
    assign take_frame = act_valid & ctrl_ena_ff;

    // result register, one cycle after the lookup word
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            res_valid_ff <= 1'b0;
            result_ff <= '0;
        end else begin
            res_valid_ff <= take_frame;
            if (take_frame) begin
                result_ff <= nxt_result;
            end
        end
    end

    assign res_valid = res_valid_ff;
    assign result = result_ff;

    // axi write channel bookkeeping: address and data taken in either order
    // a taken half waits for the response
    assign aw_held = ~awready_ff;
    assign w_held = ~wready_ff;
    assign do_write = aw_held & w_held & ~bvalid_ff;

    // write address capture; ready returns once the response is accepted
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awready_ff <= 1'b1;
            awaddr_ff <= '0;
        end else if (awready_ff && s_axi_awvalid) begin
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
        end
    end

    // write data capture
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wready_ff <= 1'b1;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (wready_ff && s_axi_wvalid) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
        end
    end

    // write response; unmapped offsets answer slverr
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff == `EAD_REG_CTRL || awaddr_ff == `EAD_REG_FRAMES
                         || awaddr_ff == `EAD_REG_RSVD || awaddr_ff == `EAD_REG_LAST)
                        ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // control register: only byte lane 0 carries bits; the clear bit is a pulse
    assign ctrl_wr = do_write && (awaddr_ff == `EAD_REG_CTRL) && wstrb_ff[0];
    assign clr_pulse = ctrl_wr && wdata_ff[`EAD_CTRL_CLR_BIT];

    // enable and clear act on the same write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ena_ff <= `EAD_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_ena_ff <= wdata_ff[`EAD_CTRL_ENA_BIT];
        end
    end

    // status counters; a frame arriving with the clear still counts as one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frames_ff <= '0;
            rsvd_ff <= '0;
        end else begin
            if (clr_pulse) begin
                frames_ff <= {31'h0, take_frame};
                rsvd_ff <= {31'h0, take_frame & nxt_any_rsvd};
            end else if (take_frame) begin
                frames_ff <= frames_ff + 32'h1;
                rsvd_ff <= rsvd_ff + {31'h0, nxt_any_rsvd};
            end
        end
    end

    // flags of the most recent frame, for debugging bad lookup entries
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            last_flags_ff <= '0;
        end else if (take_frame) begin
            last_flags_ff <= nxt_last_flags;
        end
    end

    // read channel: one read at a time, data registered
    // arready stays low until rdata is taken
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (arready_ff && s_axi_arvalid) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (s_axi_araddr)
                `EAD_REG_CTRL: rdata_ff <= {31'h0, ctrl_ena_ff};
                `EAD_REG_FRAMES: rdata_ff <= frames_ff;
                `EAD_REG_RSVD: rdata_ff <= rsvd_ff;
                `EAD_REG_LAST: rdata_ff <= {{(32 - `EAD_LAST_W){1'b0}}, last_flags_ff};
                default: begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule : ead_top

//--- testbench/ead_top_chk.sv
`timescale 1ns/1ns
// port-level checks of the decode path and the read channel
module ead_top_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic act_valid,
    input wire ead_pkg::ead_action_type action,
    input wire ead_pkg::ead_hdr_type hdr,
    input wire logic res_valid,
    input wire ead_pkg::ead_result_type result,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    import ead_pkg::*;
    logic [12:0] cnt_exp;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // counter index the primary base would give, compared one edge later
    assign cnt_exp = action.service_counter_base + 13'(action.service_class_offsets[3*hdr.class_of_service_id+:3]);
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_frame_out;
        res_valid ##0 $past(action.protection_sel) == 2'h0;
    endsequence
    a_res_cause: assert property (res_valid |-> $past(act_valid))
        else $error("result with no frame offered");
    a_push_ena: assert property (res_valid |-> result.tunnel_push_ena == (result.tunnel_label_index != 10'h0))
        else $error("tunnel push enable wrong");
    a_prim_index: assert property (s_frame_out |-> result.tunnel_label_index == $past(action.tunnel_label_index))
        else $error("primary tunnel index not kept");
    a_cnt_index: assert property (s_frame_out |-> result.service_counter_index == $past(cnt_exp))
        else $error("service counter index wrong");
    a_strip_none: assert property (res_valid && $past(action.label_strip_count) == 5'h01 |->
        result.strip_bytes == 6'h00)
        else $error("strip count one stripped bytes");
    a_fwd_decode: assert property (res_valid |->
        {1'b0, result.discard, result.redirect_loopback, result.copy_loopback}
        == ((4'h1 << $past(action.forward_selector)) >> 1))
        else $error("forward decode wrong");
    a_xtr_queue: assert property (res_valid |-> result.host_extract_queue ==
        (($past(action.forward_selector) != 2'h0 && !$past(action.pipeline_action)) ?
        $past(action.host_extract_queue) : 3'h0))
        else $error("extraction queue wrong");
    a_map_qos: assert property (res_valid && $past(action.map_key[0]) == 4'h0 |->
        result.map_a_addr[0] == {$past(action.map_table_index[0]), $past(hdr.qos_class)})
        else $error("table zero address wrong");
    a_map_b_pcp: assert property (res_valid && $past(action.map_key[2]) == 4'h5 |->
        result.map_b_addr[0] == {$past(action.map_table_index[2]), $past(hdr.pcp)})
        else $error("table two address wrong");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : ead_top_chk

bind ead_top ead_top_chk ead_top_chk_i (.*);

//--- testbench/ead_lookup_model.sv
`timescale 1ns/1ns
// lookup engine model: a fresh frame each cycle at random while run is high
module ead_lookup_model (
    input wire logic core_clk,
    input wire logic run,
    input wire logic rsvd_ok,
    output logic act_valid,
    output ead_pkg::ead_action_type action,
    output ead_pkg::ead_hdr_type hdr
);
    import ead_pkg::*;
    logic [159:0] r;
    logic [63:0] h;
    ead_action_type a;
    initial begin
        act_valid = 1'b0;
        action = '0;
        hdr = '0;
    end
    // valid may stay high, giving back-to-back frames
    always @(posedge core_clk) begin
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        h = {$urandom, $urandom};
        a = r[158:0];
        // entries keep clear of reserved codes unless a test asks for them
        if (!rsvd_ok) begin
            if (a.protection_sel == 2'h3) a.protection_sel = 2'h0;
            if (a.label_strip_count > 5'h15) a.label_strip_count = a.label_strip_count - 5'h0a;
            for (int t = 0; t < 4; t++) begin
                if (a.map_key[t] == 4'hf) a.map_key[t] = 4'he;
            end
        end
        act_valid <= run && r[159];
        action <= a;
        hdr <= h[33:0];
    end
endmodule : ead_lookup_model

//--- testbench/test_egress_action_decoder.sv
`timescale 1ns/1ns
`include "ead_map.svh"

module test_egress_action_decoder;
    import ead_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic run = 1'b0;
    logic rsvd_ok = 1'b0;
    logic act_valid, res_valid;
    ead_action_type action, pa;
    ead_hdr_type hdr, ph;
    ead_result_type result;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic ena = 1'b1;
    logic pend = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int n_frm = 0;
    int cyc = 0;

    always #5 core_clk = ~core_clk;

    ead_top ead_top_i (.*);
    ead_lookup_model ead_lookup_model_i (.core_clk, .run, .rsvd_ok, .act_valid, .action, .hdr);

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // offset added to one mapping table's base address for a key
    function automatic logic [7:0] koff(input logic [3:0] k, input ead_hdr_type h);
        logic [7:0] d8;
        d8 = {3'h0, h.drop_prec, 3'h0};
        case (k)
            4'h0: return 8'(h.qos_class);
            4'h1: return d8 + 8'(h.qos_class);
            4'h2: return 8'(h.dscp);
            4'h3: return {h.drop_prec, h.dscp};
            4'h4: return d8 + 8'(h.tos_precedence);
            4'h5: return 8'(h.pcp);
            4'h6: return d8 + 8'(h.pcp);
            4'h7: return 8'({h.dei, h.pcp});
            4'h8: return 8'(h.traffic_class);
            4'h9: return d8 + 8'(h.traffic_class);
            4'ha: return 8'(h.popped_pcp);
            4'hb: return d8 + 8'(h.popped_pcp);
            4'hc: return 8'({h.popped_dei, h.popped_pcp});
            4'hd: return 8'(h.class_of_service_id);
            4'he: return d8 + 8'(h.class_of_service_id);
            default: return 8'h00;
        endcase
    endfunction : koff

    function automatic ead_result_type expf(input ead_action_type a, input ead_hdr_type h);
        ead_result_type r;
        logic alt;
        logic [5:0] hw2, req;
        logic [11:0] ad;
        r = '0;
        alt = (a.protection_sel == 2'h1 && h.prot_active) || (a.protection_sel == 2'h2 && !h.prot_active);
        r.tunnel_label_index = alt ? a.tunnel_label_index_alt : a.tunnel_label_index;
        r.tunnel_push_ena = r.tunnel_label_index != 10'h0;
        r.maintenance_endpoint_index = alt ? a.maintenance_endpoint_index_alt : a.maintenance_endpoint_index;
        hw2 = {h.header_strip_halfwords, 1'b0};
        req = {a.label_strip_count, 1'b0};
        r.strip_bytes = hw2;
        if (a.label_strip_count == `EAD_STRIP_NONE) r.strip_bytes = 6'h00;
        if (a.label_strip_count inside {[5'h02:`EAD_STRIP_MAX]} && req <= hw2) r.strip_bytes = req;
        r.service_counter_index = (alt ? a.service_counter_base_alt : a.service_counter_base)
            + 13'(a.service_class_offsets[3*h.class_of_service_id+:3]);
        for (int t = 0; t < 4; t++) begin
            ad = {a.map_table_index[t], 3'h0} + {4'h0, koff(a.map_key[t], h)};
            if (t < 2) r.map_a_addr[t] = ad;
            else r.map_b_addr[t-2] = ad;
        end
        r.copy_loopback = a.forward_selector == `EAD_FWD_COPY;
        r.redirect_loopback = a.forward_selector == `EAD_FWD_REDIR;
        r.discard = a.forward_selector == `EAD_FWD_DISCARD;
        r.host_extraction = a.forward_selector != `EAD_FWD_NONE && a.pipeline_action == `EAD_PACT_HOST;
        r.loopback_assembly = a.forward_selector != `EAD_FWD_NONE && a.pipeline_action == `EAD_PACT_LBK;
        r.host_extract_queue = r.host_extraction ? a.host_extract_queue : 3'h0;
        return r;
    endfunction : expf

    // address and data offered together, each dropped once taken
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd_reg

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // pre-edge values: the frame taken at the last edge meets its result now
    always @(posedge core_clk) begin
        if (rstn) begin
            chk("res_valid", 128'(pend), 128'(res_valid));
            if (pend) chk("result", 128'(expf(pa, ph)), 128'(result));
        end
        pend = rstn && ena && act_valid === 1'b1;
        n_frm += int'(pend);
        pa = action;
        ph = hdr;
    end

    // hang guard, well above the roughly six hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'hf42db655));
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rd_reg(`EAD_REG_CTRL, rd, rs);
        chk("ctrl reset", 128'h1, 128'(rd));
        // clean entries, then reserved codes mixed in
        run <= 1'b1;
        repeat (300) @(posedge core_clk);
        rsvd_ok <= 1'b1;
        repeat (200) @(posedge core_clk);
        run <= 1'b0;
        rsvd_ok <= 1'b0;
        repeat (3) @(posedge core_clk);
        // disabled decoder drops every frame and counts none
        wr_reg(`EAD_REG_CTRL, 32'h0, rs);
        ena <= 1'b0;
        run <= 1'b1;
        repeat (60) @(posedge core_clk);
        run <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd_reg(`EAD_REG_FRAMES, rd, rs);
        chk("frame count", 128'(n_frm), 128'(rd));
        wr_reg(8'h10, 32'h1, rs);
        chk("unmapped bresp", 128'h2, 128'(rs));
        rd_reg(8'h10, rd, rs);
        chk("unmapped rresp", 128'h2, 128'(rs));
        chk("unmapped rdata", 128'h0, 128'(rd));
        wr_reg(`EAD_REG_CTRL, 32'h3, rs);
        ena <= 1'b1;
        rd_reg(`EAD_REG_FRAMES, rd, rs);
        chk("cleared count", 128'h0, 128'(rd));
        finish_test();
    end
endmodule : test_egress_action_decoder
